// [core/lbcs_pkg.sv]
/*
  Package for the logic block condition stack: opcodes, stack depth and
  reset values shared by the evaluator and its pending-condition store.
  Assumes a single scan clock and an active-high asynchronous reset.
*/
package lbcs_pkg;

  // Opcode width and encodings
  localparam int unsigned OP_W = 4;
  typedef enum logic [OP_W-1:0] {
    LBCS_OP_NOP          = 4'h0,
    LBCS_OP_LOAD         = 4'h1,
    LBCS_OP_LOAD_INV     = 4'h2,
    LBCS_OP_AND          = 4'h3,
    LBCS_OP_AND_INV      = 4'h4,
    LBCS_OP_OR           = 4'h5,
    LBCS_OP_OR_INV       = 4'h6,
    LBCS_OP_BLOCK_AND    = 4'h7,
    LBCS_OP_BLOCK_OR     = 4'h8,
    LBCS_OP_OUT          = 4'h9,
    LBCS_OP_OUT_INV      = 4'hA,
    LBCS_OP_LINE_END     = 4'hB
  } lbcs_op_t;

  // Eight blocks deferred means seven pending entries beyond the running one
  localparam int unsigned LBCS_BLOCKS    = 8;
  localparam int unsigned LBCS_DEPTH     = LBCS_BLOCKS - 1;
  localparam int unsigned LBCS_PTR_W     = 3;
  localparam logic [LBCS_PTR_W-1:0] LBCS_PTR_RST  = 3'h0;
  localparam logic [LBCS_PTR_W-1:0] LBCS_PTR_FULL = 3'h7;
  localparam logic [LBCS_PTR_W-1:0] LBCS_PTR_ONE  = 3'h1;

  // Evaluator phase: two-bit code; LBCS_ST_ERROR to LBCS_ST_LINE_START flips both bits
  typedef enum logic [1:0] {
    LBCS_ST_LINE_START = 2'b00,
    LBCS_ST_IN_LINE    = 2'b01,
    LBCS_ST_ERROR      = 2'b11
  } lbcs_state_t;

endpackage : lbcs_pkg

// [core/lbcs_stack.sv]
/*
  Pending-condition store: a small LIFO of single-bit conditions with
  a registered top-of-stack output.
  Assumes the caller never pushes when full nor pops when empty.
*/
`timescale 1ns/1ps
module lbcs_stack
  import lbcs_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  push,
  input  wire logic                  pop,
  input  wire logic                  push_bit,
  output logic      [LBCS_PTR_W-1:0] count,
  output logic                       top_bit
);

  logic [LBCS_DEPTH-1:0] mem_q, mem_d;
  logic [LBCS_PTR_W-1:0] cnt_q, cnt_d;
  logic                  top_q, top_d;

  // Next contents, count and registered top entry
  always_comb begin
    mem_d = mem_q;
    cnt_d = cnt_q;
    top_d = top_q;
    if (push) begin
      mem_d[cnt_q] = push_bit;
      cnt_d        = cnt_q + LBCS_PTR_ONE;
      top_d        = push_bit;
    end else if (pop) begin
      cnt_d = cnt_q - LBCS_PTR_ONE;
      top_d = (cnt_d == LBCS_PTR_RST) ? 1'b0 : mem_q[cnt_d - LBCS_PTR_ONE];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_q <= '0;
      cnt_q <= LBCS_PTR_RST;
      top_q <= 1'b0;
    end else begin
      mem_q <= mem_d;
      cnt_q <= cnt_d;
      top_q <= top_d;
    end
  end

  assign count   = cnt_q;
  assign top_bit = top_q;

endmodule : lbcs_stack

// [core/lbcs_core.sv]
/*
  Boolean evaluation core: running execution condition, pending-condition
  stack, block combines and output drive, one instruction per clock.
  Assumes a sequencer presents one opcode and operand bit per valid cycle.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - Load or inverted load sets condition to operand or its complement.
// - A load mid-line pushes the running condition before restarting.
// - Block AND merges running and newest pending condition, pops it.
// - Block OR is the same but forms the OR.
// - Combines act on the two newest conditions, whatever their source.
// - Up to eight blocks deferred, i.e. seven pending combines.
// - Interleaved combines allow unlimited blocks in one line.
// - Interleaved and deferred combining give the same result.
// - Output latches the condition into its bit next cycle; the bit holds until the next output.
module lbcs_core
  import lbcs_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  instr_valid,
  input  wire lbcs_op_t              instr_op,
  input  wire logic                  operand_bit,
  input  wire logic                  error_clear,
  output logic                       exec_cond,
  output logic                       out_valid,
  output logic                       out_bit,
  output logic                       program_error,
  output logic      [LBCS_PTR_W-1:0] pending_count
);

  lbcs_state_t st_q, st_d;
  logic        cond_q, cond_d;
  logic        ov_q, ov_d;
  logic        ob_q, ob_d;
  logic        err_q, err_d;
  logic        push, pop, top_bit;
  logic        is_load, is_comb, overflow, underflow;

  // All checks below run on the scan clock, off during reset
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Instruction decode
  assign is_load = instr_valid && (instr_op == LBCS_OP_LOAD ||
                                   instr_op == LBCS_OP_LOAD_INV);
  assign is_comb = instr_valid && (instr_op == LBCS_OP_BLOCK_AND ||
                                   instr_op == LBCS_OP_BLOCK_OR);
  assign overflow  = is_load && st_q == LBCS_ST_IN_LINE &&
                     pending_count == LBCS_PTR_FULL;
  assign underflow = is_comb && pending_count == LBCS_PTR_RST;
  assign push = is_load && st_q == LBCS_ST_IN_LINE && !overflow;
  assign pop  = is_comb && !underflow && st_q != LBCS_ST_ERROR;

  lbcs_stack u_stack (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .push     (push),
    .pop      (pop),
    .push_bit (cond_q),
    .count    (pending_count),
    .top_bit  (top_bit)
  );

  // Next state, condition, output and error flag
  always_comb begin
    st_d   = st_q;
    cond_d = cond_q;
    ov_d   = 1'b0;
    ob_d   = ob_q;
    err_d  = err_q;
    if (error_clear) begin
      err_d = 1'b0;
    end
    if (instr_valid) begin
      case (instr_op)
        LBCS_OP_LOAD, LBCS_OP_LOAD_INV: begin
          if (st_q != LBCS_ST_ERROR) begin
            cond_d = (instr_op == LBCS_OP_LOAD) ? operand_bit : !operand_bit;
            st_d   = overflow ? LBCS_ST_ERROR : LBCS_ST_IN_LINE;
          end
        end
        LBCS_OP_AND:     cond_d = cond_q & operand_bit;
        LBCS_OP_AND_INV: cond_d = cond_q & !operand_bit;
        LBCS_OP_OR:      cond_d = cond_q | operand_bit;
        LBCS_OP_OR_INV:  cond_d = cond_q | !operand_bit;
        LBCS_OP_BLOCK_AND: begin
          if (pop) begin
            cond_d = cond_q & top_bit;
          end else if (underflow) begin
            st_d = LBCS_ST_ERROR;
          end
        end
        LBCS_OP_BLOCK_OR: begin
          if (pop) begin
            cond_d = cond_q | top_bit;
          end else if (underflow) begin
            st_d = LBCS_ST_ERROR;
          end
        end
        LBCS_OP_OUT, LBCS_OP_OUT_INV: begin
          ov_d = 1'b1;
          ob_d = (instr_op == LBCS_OP_OUT) ? cond_q : !cond_q;
        end
        LBCS_OP_LINE_END: st_d = LBCS_ST_LINE_START;
        default: ;
      endcase
    end
    if (overflow || underflow) begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q   <= LBCS_ST_LINE_START;
      cond_q <= 1'b0;
      ov_q   <= 1'b0;
      ob_q   <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      cond_q <= cond_d;
      ov_q   <= ov_d;
      ob_q   <= ob_d;
      err_q  <= err_d;
    end
  end

  assign exec_cond     = cond_q;
  assign out_valid     = ov_q;
  assign out_bit       = ob_q;
  assign program_error = err_q;

  // Assertions
  load_sets_cond_a: assert property (
    is_load && st_q != LBCS_ST_ERROR |=> exec_cond ==
      ($past(instr_op) == LBCS_OP_LOAD ? $past(operand_bit)
                                         : !$past(operand_bit)))
    else $error("load did not set condition");
  push_mid_line_a: assert property (
    push |=> pending_count == $past(pending_count) + LBCS_PTR_ONE)
    else $error("mid-line load did not push");
  first_no_push_a: assert property (
    is_load && st_q == LBCS_ST_LINE_START |=> $stable(pending_count))
    else $error("line-start load pushed");
  block_and_a: assert property (
    pop && instr_op == LBCS_OP_BLOCK_AND |=>
      exec_cond == ($past(cond_q) & $past(top_bit)))
    else $error("block AND wrong");
  block_or_a: assert property (
    pop && instr_op == LBCS_OP_BLOCK_OR |=>
      exec_cond == ($past(cond_q) | $past(top_bit)))
    else $error("block OR wrong");
  pop_count_a: assert property (
    pop |=> pending_count == $past(pending_count) - LBCS_PTR_ONE)
    else $error("combine did not consume entry");
  depth_bound_a: assert property (
    push |-> pending_count != LBCS_PTR_FULL)
    else $error("push into full pending store");
  output_drive_a: assert property (
    instr_valid && instr_op == LBCS_OP_OUT |=> out_valid && out_bit ==
      $past(cond_q))
    else $error("output not following condition");
  output_inv_a: assert property (
    instr_valid && instr_op == LBCS_OP_OUT_INV |=> out_valid && out_bit ==
      !$past(cond_q))
    else $error("inverted output not following condition");
  error_raise_a: assert property (
    overflow || underflow |=> program_error)
    else $error("program error not raised");
  overflow_hold_a: assert property (
    overflow |=> $stable(pending_count))
    else $error("overflow changed pending store");

  // Main scenarios: deferred chain, overflow, interleaved chain
  deferred_full_c: cover property (
    pending_count == LBCS_PTR_FULL ##1 pop);
  overflow_c: cover property (overflow);
  interleave_c: cover property (
    push ##1 pop ##1 push ##1 pop);

endmodule : lbcs_core

// [verif/lbcs_core_tb.sv]
/*
  Self-checking bench for the condition stack core: loads, combines,
  deferred and interleaved chains, output drive and program errors.
  Assumes the core takes one instruction per clock and answers next cycle.
*/
`timescale 1ns/1ps
module lbcs_core_tb;
  import lbcs_pkg::*;
  logic                  clk = 1'b0;
  logic                  sys_rst = 1'b1;
  logic                  instr_valid = 1'b0;
  lbcs_op_t              instr_op = LBCS_OP_NOP;
  logic                  operand_bit = 1'b0;
  logic                  error_clear = 1'b0;
  logic                  exec_cond, out_valid, out_bit, program_error;
  logic [LBCS_PTR_W-1:0] pending_count;
  int                    n_errors = 0;
  int                    checks = 0;

  lbcs_core u_dut (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_op(instr_op), .operand_bit(operand_bit),
    .error_clear(error_clear), .exec_cond(exec_cond), .out_valid(out_valid),
    .out_bit(out_bit), .program_error(program_error),
    .pending_count(pending_count));

  // Scan clock, 5 ns period
  always #2.5 clk = ~clk;

  task complete_run;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_bit

  task chk_cnt(input logic [LBCS_PTR_W-1:0] got,
               input logic [LBCS_PTR_W-1:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t count %h exp %h", $time, got, exp);
    end
  endtask : chk_cnt

  // One instruction taken at the next edge; valid stays up
  task issue(input lbcs_op_t op, input logic b);
    instr_valid = 1'b1;
    instr_op = op;
    operand_bit = b;
    @(posedge clk);
    #1;
  endtask : issue

  task idle;
    instr_valid = 1'b0;
    @(posedge clk);
    #1;
  endtask : idle

  task t_walk;
    issue(LBCS_OP_LOAD, 1'b1);
    chk_bit(exec_cond, 1'b1);
    chk_cnt(pending_count, 3'h0);
    issue(LBCS_OP_LOAD_INV, 1'b1);
    chk_bit(exec_cond, 1'b0);
    chk_cnt(pending_count, 3'h1);
    issue(LBCS_OP_BLOCK_OR, 1'b0);
    chk_bit(exec_cond, 1'b1);
    chk_cnt(pending_count, 3'h0);
    issue(LBCS_OP_OUT, 1'b0);
    chk_bit(out_valid, 1'b1);
    chk_bit(out_bit, 1'b1);
    idle();
    chk_bit(out_valid, 1'b0);
    $display("test walk done");
  endtask : t_walk

  task t_nest;
    issue(LBCS_OP_LINE_END, 1'b0);
    issue(LBCS_OP_LOAD, 1'b0);
    issue(LBCS_OP_LOAD, 1'b0);
    issue(LBCS_OP_LOAD, 1'b1);
    issue(LBCS_OP_BLOCK_OR, 1'b0);
    chk_bit(exec_cond, 1'b1);
    chk_cnt(pending_count, 3'h1);
    issue(LBCS_OP_BLOCK_AND, 1'b0);
    chk_bit(exec_cond, 1'b0);
    issue(LBCS_OP_OUT, 1'b0);
    chk_bit(out_bit, 1'b0);
    $display("test nest done");
  endtask : t_nest

  // Plain contact ops, no-op, then both output forms
  task t_ops;
    issue(LBCS_OP_LINE_END, 1'b0);
    issue(LBCS_OP_LOAD, 1'b1);
    issue(LBCS_OP_AND, 1'b1);
    chk_bit(exec_cond, 1'b1);
    issue(LBCS_OP_AND_INV, 1'b1);
    chk_bit(exec_cond, 1'b0);
    issue(LBCS_OP_OR, 1'b0);
    chk_bit(exec_cond, 1'b0);
    issue(LBCS_OP_OR_INV, 1'b0);
    chk_bit(exec_cond, 1'b1);
    issue(LBCS_OP_NOP, 1'b0);
    chk_bit(exec_cond, 1'b1);
    issue(LBCS_OP_LOAD_INV, 1'b1);
    issue(LBCS_OP_OR, 1'b0);
    chk_bit(exec_cond, 1'b0);
    issue(LBCS_OP_BLOCK_OR, 1'b0);
    chk_bit(exec_cond, 1'b1);
    issue(LBCS_OP_OUT, 1'b0);
    chk_bit(out_bit, 1'b1);
    issue(LBCS_OP_OUT_INV, 1'b0);
    chk_bit(out_valid, 1'b1);
    chk_bit(out_bit, 1'b0);
    idle();
    $display("test ops done");
  endtask : t_ops

  task chain(input logic defer, input logic use_or, input int n,
             input logic [15:0] bits);
    lbcs_op_t comb;
    logic     exp;
    comb = use_or ? LBCS_OP_BLOCK_OR : LBCS_OP_BLOCK_AND;
    exp = bits[0];
    for (int i = 1; i < n; i++) exp = use_or ? exp | bits[i] : exp & bits[i];
    issue(LBCS_OP_LINE_END, 1'b0);
    for (int i = 0; i < n; i++) begin
      if (i[0]) issue(LBCS_OP_LOAD_INV, ~bits[i]);
      else issue(LBCS_OP_LOAD, bits[i]);
      if (!defer && i > 0) issue(comb, 1'b0);
    end
    if (defer) begin
      chk_cnt(pending_count, 3'(n - 1));
      for (int i = 1; i < n; i++) issue(comb, 1'b0);
    end
    issue(LBCS_OP_OUT, 1'b0);
    chk_bit(out_bit, exp);
    chk_bit(program_error, 1'b0);
    chk_cnt(pending_count, 3'h0);
    $display("test chain done");
  endtask : chain

  task t_err;
    issue(LBCS_OP_LINE_END, 1'b0);
    issue(LBCS_OP_LOAD, 1'b1);
    issue(LBCS_OP_BLOCK_AND, 1'b0);
    chk_bit(program_error, 1'b1);
    chk_cnt(pending_count, 3'h0);
    error_clear = 1'b1;
    issue(LBCS_OP_BLOCK_OR, 1'b0);
    error_clear = 1'b0;
    chk_bit(program_error, 1'b1);
    issue(LBCS_OP_LINE_END, 1'b0);
    instr_valid = 1'b0;
    error_clear = 1'b1;
    @(posedge clk);
    #1;
    error_clear = 1'b0;
    chk_bit(program_error, 1'b0);
    for (int i = 0; i < 9; i++) issue(LBCS_OP_LOAD, 1'b1);
    chk_bit(program_error, 1'b1);
    chk_cnt(pending_count, 3'h7);
    idle();
    $display("test error done");
  endtask : t_err

  // Mid-run reset with a full store and a raised error
  task t_rst;
    sys_rst = 1'b1;
    @(posedge clk);
    #1;
    chk_bit(program_error, 1'b0);
    chk_cnt(pending_count, 3'h0);
    sys_rst = 1'b0;
    issue(LBCS_OP_LOAD, 1'b1);
    chk_cnt(pending_count, 3'h0);
    issue(LBCS_OP_LOAD, 1'b0);
    chk_cnt(pending_count, 3'h1);
    idle();
    $display("test reset done");
  endtask : t_rst

  initial begin
    #20000;
    n_errors++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge clk);
    #1;
    chk_bit(exec_cond | out_valid | out_bit | program_error, 1'b0);
    chk_cnt(pending_count, 3'h0);
    sys_rst = 1'b0;
    t_walk();
    t_nest();
    t_ops();
    chain(1'b0, 1'b0, 8, 16'h00FF);
    chain(1'b1, 1'b0, 8, 16'h00FF);
    chain(1'b1, 1'b0, 8, 16'h00FB);
    chain(1'b1, 1'b1, 8, 16'h0010);
    chain(1'b0, 1'b1, 8, 16'h0010);
    chain(1'b0, 1'b1, 16, 16'h4000);
    chain(1'b0, 1'b0, 16, 16'hFFFF);
    t_err();
    t_rst();
    complete_run();
  end
endmodule : lbcs_core_tb
